/* File: core/sts_sequencer.sv */
// source transfer sequencer: supervises two supplies and moves the load between them
// assumes synchronous per-detection in-range inputs and an apb master on pclk
// What this block does
// - generator fail timer runs 300 s after start
// - fail timer expiry raises alarm if enabled
// - alarm enable configurable, disabled after reset
// - alarm clears when either source in range
// - fail timer counts only with external power
// - on-load test timed, alarm when unfinished
// - off-load test timed, alarm when unfinished
// - utility mode: normal fails, move to alternate
// - auto return re-transfers to recovered normal
// - generator mode: normal fails, start generator
// - generator mode: transfer only when generator ready
// - cool-down signal only with the load on normal
// - utility mode indicators: on or blinking
// - utility mode: indicator lit while one source good
// - generator side indicator off without start
// - status ok when all enabled detections good
// - status out range on any enabled bad
// - starting generator reports out range
// - preferred normal source selectable
// - generator stop 60 s after normal closes
// - normal failing cancels the re-transfer delay
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module sts_sequencer
    import sts_pkg::*;
#(
    parameter int SEC_CYCLES = SEC_CYCLES_DEF,
    parameter logic [SEC_W-1:0] RETRANSFER_S = RETRANSFER_S_DEF
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // source detections, one bit per detection, high when in range
    input wire logic [DET_N-1:0] src1_det,
    input wire logic [DET_N-1:0] src2_det,
    // generator and test feedback
    input wire logic ext_power,
    input wire logic gen_ready,
    input wire logic test_done,
    // switch and generator commands
    output logic load_on_alt,
    output logic gen_start,
    output logic gen_cool,
    // indicators
    output logic src1_led,
    output logic src2_led,
    output logic gen_alarm
);
    typedef struct packed {
        sts_state_e st;
        logic load_alt;
        logic gen_start;
        logic gen_cool;
        logic gen_alarm;
        logic on_alarm;
        logic off_alarm;
        logic on_run;
        logic off_run;
        logic app_ug;
        logic auto_ret;
        logic alarm_en;
        logic pref;
        logic [7:0] det_en;
        logic [PRESC_W-1:0] presc;
        logic blink;
        logic [SEC_W-1:0] sec_cnt;
        logic [SEC_W-1:0] test_cnt;
        logic [1:0] stat1;
        logic [1:0] stat2;
        logic led1;
        logic led2;
        logic [31:0] rdata;
    } sts_state_s;

    sts_state_s r;
    sts_state_s next_r;

    logic ok1;
    logic ok2;
    logic ok_n;
    logic ok_a;
    logic tick;
    logic setup;
    logic wr;
    logic mapped;
    logic tmr_clr;
    logic fail_set;
    logic [1:0] st_n;
    logic [1:0] st_a;

    // a disabled detection never counts against its source
    assign ok1 = &(src1_det | ~r.det_en[DET_N-1:0]);
    assign ok2 = &(src2_det | ~r.det_en[2*DET_N-1:DET_N]);
    assign ok_n = r.pref ? ok2 : ok1;
    assign ok_a = r.pref ? ok1 : ok2;
    assign tick = (r.presc == PRESC_W'(SEC_CYCLES - 1));

    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite;
    assign mapped = (paddr == REG_CTRL) || (paddr == REG_CMD) || (paddr == REG_DET_EN)
        || (paddr == REG_STATUS) || (paddr == REG_ALARM) || (paddr == REG_TIMER);
    assign pready = psel && penable;
    assign pslverr = psel && penable && !mapped;
    assign tmr_clr = wr && (paddr == REG_CMD) && pwdata[CMD_TMR_CLR];

    // fail timer expiry with the generator still not ready
    assign fail_set = (r.st == ST_GEN_START) && (r.sec_cnt == GENSET_FAIL_S)
        && !gen_ready && r.alarm_en;

    always_comb begin
        next_r = r;
        next_r.presc = tick ? '0 : r.presc + 1'b1;
        if (tick) begin
            next_r.blink = !r.blink;
        end

        // state timer, saturating; the fail timer needs external power
        if (tick && (r.sec_cnt != '1)) begin
            if ((r.st != ST_GEN_START) || ext_power) begin
                next_r.sec_cnt = r.sec_cnt + 1'b1;
            end
        end

        unique case (r.st)
            ST_NORMAL: begin
                if (!ok_n) begin
                    if (r.app_ug) begin
                        next_r.st = ST_GEN_START;
                        next_r.gen_start = 1'b1;
                        next_r.sec_cnt = '0;
                    end else if (ok_a) begin
                        next_r.st = ST_ON_ALT;
                        next_r.load_alt = 1'b1;
                    end
                end
            end
            ST_GEN_START: begin
                if (ok_n) begin
                    next_r.st = ST_COOL;
                    next_r.gen_cool = 1'b1;
                    next_r.sec_cnt = '0;
                end else if (gen_ready && ok_a) begin
                    next_r.st = ST_ON_ALT;
                    next_r.load_alt = 1'b1;
                end
            end
            ST_ON_ALT: begin
                if (ok_n && (r.auto_ret || !ok_a)) begin
                    next_r.st = ST_RETRANS;
                    next_r.sec_cnt = '0;
                end
            end
            ST_RETRANS: begin
                if (!ok_n) begin
                    next_r.st = ST_ON_ALT;
                end else if ((r.sec_cnt >= RETRANSFER_S) || !ok_a) begin
                    next_r.load_alt = 1'b0;
                    next_r.sec_cnt = '0;
                    if (r.app_ug) begin
                        next_r.st = ST_COOL;
                        next_r.gen_cool = 1'b1;
                    end else begin
                        next_r.st = ST_NORMAL;
                    end
                end
            end
            ST_COOL: begin
                if (!ok_n) begin
                    next_r.st = ST_GEN_START;
                    next_r.gen_cool = 1'b0;
                    next_r.sec_cnt = '0;
                end else if (r.sec_cnt >= GENSET_COOL_S) begin
                    next_r.st = ST_NORMAL;
                    next_r.gen_cool = 1'b0;
                    next_r.gen_start = 1'b0;
                end
            end
        endcase

        // generator alarm: the set wins over the clear
        if (fail_set) begin
            next_r.gen_alarm = 1'b1;
        end else if (ok_a || ok_n || !r.alarm_en) begin
            next_r.gen_alarm = 1'b0;
        end

        // load tests: time against their fixed length
        if (tick && r.test_cnt != '1) begin
            next_r.test_cnt = r.test_cnt + 1'b1;
        end
        if (r.on_run) begin
            if (test_done) begin
                next_r.on_run = 1'b0;
            end else if (r.test_cnt >= ON_LOAD_TEST_S) begin
                next_r.on_run = 1'b0;
                next_r.on_alarm = 1'b1;
            end
        end
        if (r.off_run) begin
            if (test_done) begin
                next_r.off_run = 1'b0;
            end else if (r.test_cnt >= OFF_LOAD_TEST_S) begin
                next_r.off_run = 1'b0;
                next_r.off_alarm = 1'b1;
            end
        end

        // source status and indicators
        st_n = ok_n ? SRC_OK : SRC_OUTR;
        st_a = ok_a ? SRC_OK : SRC_OUTR;
        if (r.app_ug) begin
            if (!r.gen_start) begin
                st_a = SRC_OFF;
            end else if (r.st == ST_GEN_START && !gen_ready) begin
                st_a = SRC_OUTR;
            end
        end
        next_r.stat1 = r.pref ? st_a : st_n;
        next_r.stat2 = r.pref ? st_n : st_a;
        // never steadily dark in utility mode: ok steady, out range blinking
        next_r.led1 = (r.stat1 == SRC_OK) || ((r.stat1 == SRC_OUTR) && r.blink);
        next_r.led2 = (r.stat2 == SRC_OK) || ((r.stat2 == SRC_OUTR) && r.blink);

        // apb writes
        if (wr) begin
            unique case (paddr)
                REG_CTRL: begin
                    next_r.app_ug = pwdata[CTRL_APP_UG];
                    next_r.auto_ret = pwdata[CTRL_AUTO_RET];
                    next_r.alarm_en = pwdata[CTRL_ALARM_EN];
                    next_r.pref = pwdata[CTRL_PREF];
                end
                REG_CMD: begin
                    if (pwdata[CMD_ON_TEST] || pwdata[CMD_OFF_TEST]) begin
                        next_r.test_cnt = '0;
                    end
                    if (pwdata[CMD_ON_TEST]) begin
                        next_r.on_run = 1'b1;
                    end
                    if (pwdata[CMD_OFF_TEST]) begin
                        next_r.off_run = 1'b1;
                    end
                end
                REG_DET_EN: next_r.det_en = pwdata[7:0];
                REG_ALARM: begin
                    // a test alarm raised in this cycle survives the clear
                    if (pwdata[ALM_ON_TEST] && !(next_r.on_alarm && !r.on_alarm)) begin
                        next_r.on_alarm = 1'b0;
                    end
                    if (pwdata[ALM_OFF_TEST] && !(next_r.off_alarm && !r.off_alarm)) begin
                        next_r.off_alarm = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        if (tmr_clr) begin
            next_r.sec_cnt = '0;
            next_r.test_cnt = '0;
            next_r.presc = '0;
        end

        // read data captured in the setup cycle
        if (setup && !pwrite) begin
            unique case (paddr)
                REG_CTRL: next_r.rdata = {28'h0, r.pref, r.alarm_en, r.auto_ret, r.app_ug};
                REG_DET_EN: next_r.rdata = {24'h0, r.det_en};
                REG_STATUS: next_r.rdata = {18'h0, r.stat2, r.stat1, r.on_run, r.off_run,
                    r.gen_cool, r.gen_start, r.load_alt, ok2, ok1, r.st};
                REG_ALARM: next_r.rdata = {29'h0, r.off_alarm, r.on_alarm, r.gen_alarm};
                REG_TIMER: next_r.rdata = {6'h0, r.test_cnt, 6'h0, r.sec_cnt};
                default: next_r.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.st <= ST_NORMAL;
            r.det_en <= DET_EN_RST;
        end else begin
            r <= next_r;
        end
    end

    assign prdata = r.rdata;
    assign load_on_alt = r.load_alt;
    assign gen_start = r.gen_start;
    assign gen_cool = r.gen_cool;
    assign src1_led = r.led1;
    assign src2_led = r.led2;
    assign gen_alarm = r.gen_alarm;

    property p_fail_alarm;
        @(posedge pclk) disable iff (!presetn)
        $rose(r.gen_alarm) |-> $past(r.alarm_en) && $past(r.st == ST_GEN_START)
            && ($past(r.sec_cnt) == GENSET_FAIL_S);
    endproperty
    a_fail_alarm: assert property (p_fail_alarm) else $error("gen alarm without expiry");

    property p_alarm_disabled;
        @(posedge pclk) disable iff (!presetn)
        !r.alarm_en |=> !r.gen_alarm;
    endproperty
    a_alarm_disabled: assert property (p_alarm_disabled) else $error("alarm while off");

    property p_alarm_clear;
        @(posedge pclk) disable iff (!presetn)
        (ok_n || ok_a) && !fail_set |=> !r.gen_alarm;
    endproperty
    a_alarm_clear: assert property (p_alarm_clear) else $error("alarm not cleared");

    property p_no_power_hold;
        @(posedge pclk) disable iff (!presetn)
        (r.st == ST_GEN_START) && !ext_power && !ok_n && !tmr_clr
            && !(gen_ready && ok_a) |=> $stable(r.sec_cnt);
    endproperty
    a_no_power_hold: assert property (p_no_power_hold) else $error("fail timer ran");

    property p_uu_transfer;
        @(posedge pclk) disable iff (!presetn)
        (r.st == ST_NORMAL) && !r.app_ug && !ok_n && ok_a |=> r.load_alt;
    endproperty
    a_uu_transfer: assert property (p_uu_transfer) else $error("no transfer to alt");

    property p_ug_start;
        @(posedge pclk) disable iff (!presetn)
        (r.st == ST_NORMAL) && r.app_ug && !ok_n |=> r.gen_start && !r.load_alt;
    endproperty
    a_ug_start: assert property (p_ug_start) else $error("generator not started");

    property p_ready_gate;
        @(posedge pclk) disable iff (!presetn)
        $rose(r.load_alt) && r.app_ug |-> $past(gen_ready) || $past(r.st == ST_NORMAL);
    endproperty
    a_ready_gate: assert property (p_ready_gate) else $error("transfer before ready");

    property p_cool_after;
        @(posedge pclk) disable iff (!presetn)
        r.gen_cool |-> !r.load_alt && r.gen_start;
    endproperty
    a_cool_after: assert property (p_cool_after) else $error("cool while on alternate");

    property p_cancel;
        @(posedge pclk) disable iff (!presetn)
        (r.st == ST_RETRANS) && !ok_n |=> (r.st == ST_ON_ALT) && r.load_alt;
    endproperty
    a_cancel: assert property (p_cancel) else $error("re-transfer not cancelled");

    property p_gen_led_off;
        @(posedge pclk) disable iff (!presetn)
        r.app_ug && !r.gen_start && !r.pref ##1 r.app_ug && !r.gen_start && !r.pref |=> !r.led2;
    endproperty
    a_gen_led_off: assert property (p_gen_led_off) else $error("generator led lit");
endmodule // sts_sequencer

/* File: include/sts_pkg.sv */
// constants, register map and state encoding of the source transfer sequencer
// assumes a single 40 MHz clock; all delays are timed in whole seconds
package sts_pkg;
    // clock and time base
    localparam int CLK_PERIOD_NS = 25;
    localparam int CLK_HZ = 1_000_000_000 / CLK_PERIOD_NS;
    localparam int SEC_CYCLES_DEF = CLK_HZ * 1;
    localparam int PRESC_W = 26;
    localparam int SEC_W = 10;

    // delay figures in seconds
    localparam logic [SEC_W-1:0] GENSET_FAIL_S = 10'd300;
    localparam logic [SEC_W-1:0] ON_LOAD_TEST_S = 10'd0;
    localparam logic [SEC_W-1:0] OFF_LOAD_TEST_S = 10'd0;
    localparam logic [SEC_W-1:0] GENSET_COOL_S = 10'd60;
    localparam logic [SEC_W-1:0] RETRANSFER_S_DEF = 10'd60;

    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CMD = 8'h04;
    localparam logic [7:0] REG_DET_EN = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_ALARM = 8'h10;
    localparam logic [7:0] REG_TIMER = 8'h14;

    // ctrl fields
    localparam int CTRL_APP_UG = 0;
    localparam int CTRL_AUTO_RET = 1;
    localparam int CTRL_ALARM_EN = 2;
    localparam int CTRL_PREF = 3;
    // cmd fields (write-one pulses)
    localparam int CMD_ON_TEST = 0;
    localparam int CMD_OFF_TEST = 1;
    localparam int CMD_TMR_CLR = 2;
    // alarm fields
    localparam int ALM_GEN = 0;
    localparam int ALM_ON_TEST = 1;
    localparam int ALM_OFF_TEST = 2;

    localparam int DET_N = 4;
    localparam logic [7:0] DET_EN_RST = 8'hff;

    // per-source status codes
    localparam logic [1:0] SRC_OFF = 2'b00;
    localparam logic [1:0] SRC_OK = 2'b01;
    localparam logic [1:0] SRC_OUTR = 2'b10;

    typedef enum logic [2:0] {
        ST_NORMAL = 3'b000,
        ST_GEN_START = 3'b001,
        ST_ON_ALT = 3'b010,
        ST_RETRANS = 3'b011,
        ST_COOL = 3'b100
    } sts_state_e;
endpackage

/* File: test/sts_partner.sv */
// partner model: the two supplies and the generator set facing the sequencer
// assumes the bench sets supply health; a generator needs GEN_DLY clocks to get ready
`timescale 1ns/1ps
module sts_partner #(
    parameter int GEN_DLY = 40
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // supply health from the bench
    input wire logic [3:0] nrm_det,
    input wire logic [3:0] alt_det,
    input wire logic pref,
    input wire logic gen_ok,
    // generator command
    input wire logic gen_start,
    // towards the sequencer
    output logic [3:0] src1_det,
    output logic [3:0] src2_det,
    output logic gen_ready
);
    int run;
    // the preferred supply lands on whichever input the setting names
    assign src1_det = pref ? alt_det : nrm_det;
    assign src2_det = pref ? nrm_det : alt_det;
    // a dead or stopped generator never reports ready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run <= 0;
        end else if (!gen_start || !gen_ok) begin
            run <= 0;
        end else if (run < GEN_DLY) begin
            run <= run + 1;
        end
    end
    assign gen_ready = gen_start && gen_ok && run >= GEN_DLY;
endmodule // sts_partner

/* File: test/testbench.sv */
// self-checking bench of the source transfer sequencer
// assumes a one-second tick of SC clocks and a short re-transfer delay
`timescale 1ns/1ps
module testbench;
    import sts_pkg::*;
    localparam int SC = 4;
    localparam logic [SEC_W-1:0] RT = 10'd2;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, gen_ready, load_on_alt, gen_start, gen_cool;
    logic src1_led, src2_led, gen_alarm;
    logic [3:0] src1_det, src2_det;
    logic ext_power = 1'b0;
    logic test_done = 1'b0;
    logic [3:0] nrm_det = 4'hf;
    logic [3:0] alt_det = 4'hf;
    logic gen_ok = 1'b1;
    logic pref = 1'b0;
    logic [31:0] rd;
    logic [31:0] rv;
    logic er;
    logic [7:0] en;
    int fail_count = 0;
    int n_checks = 0;
    int ones;

    always #12.5 pclk = ~pclk;

    sts_sequencer #(.SEC_CYCLES(SC), .RETRANSFER_S(RT)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .src1_det(src1_det),
        .src2_det(src2_det), .ext_power(ext_power), .gen_ready(gen_ready),
        .test_done(test_done), .load_on_alt(load_on_alt), .gen_start(gen_start),
        .gen_cool(gen_cool), .src1_led(src1_led), .src2_led(src2_led), .gen_alarm(gen_alarm));

    sts_partner partner (.pclk(pclk), .presetn(presetn), .nrm_det(nrm_det), .alt_det(alt_det),
        .pref(pref), .gen_ok(gen_ok), .gen_start(gen_start), .src1_det(src1_det),
        .src2_det(src2_det), .gen_ready(gen_ready));

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer; read data and error land in rd and er
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        chk(32'(pready), 1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic sig(input int s);
        case (s)
            0: return load_on_alt;
            1: return gen_start;
            2: return gen_cool;
            3: return src1_led;
            4: return src2_led;
            default: return gen_alarm;
        endcase
    endfunction

    task automatic wait_sig(input int s, input logic v, input int n);
        int k;
        k = 0;
        while (sig(s) !== v && k < n) begin
            @(posedge pclk);
            k++;
        end
        chk(32'(sig(s)), 32'(v));
    endtask

    // counts the cycles out of 18 in which an indicator is lit
    task automatic watch(input int s);
        ones = 0;
        repeat (18) begin
            @(posedge pclk);
            if (sig(s) === 1'b1) begin
                ones++;
            end
        end
    endtask

    task automatic sec(input int n);
        repeat (n * SC) @(posedge pclk);
    endtask

    function automatic logic [1:0] es(input logic [3:0] d, input logic [3:0] e);
        return (&(d | ~e)) ? SRC_OK : SRC_OUTR;
    endfunction

    initial begin
        repeat (40000) @(posedge pclk);
        fail_count++;
        give_verdict();
    end

    initial begin
        void'($urandom(54790));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, REG_CTRL, 0);
        chk(rd, 0);
        apb(0, REG_DET_EN, 0);
        chk(rd, 32'(DET_EN_RST));
        apb(0, 8'h40, 0);
        chk(32'(er), 1);
        chk(rd, 0);
        repeat (8) begin
            rv = $urandom;
            apb(1, REG_CTRL, rv);
            apb(0, REG_CTRL, 0);
            chk(rd, rv & 32'hf);
        end
        apb(1, REG_CTRL, 0);
        // utility-utility transfer, indicators, auto return and cancel
        nrm_det <= 4'he;
        wait_sig(0, 1'b1, 3);
        apb(0, REG_STATUS, 0);
        chk(32'({rd[2:0], rd[11:10], rd[13:12]}), 32'({ST_ON_ALT, SRC_OUTR, SRC_OK}));
        watch(3);
        chk(32'(ones > 0 && ones < 18), 1);
        watch(4);
        chk(ones, 18);
        nrm_det <= 4'hf;
        sec(3);
        chk(32'(load_on_alt), 1);
        apb(1, REG_CTRL, 32'h2);
        apb(0, REG_STATUS, 0);
        chk(32'(rd[2:0]), 32'(ST_RETRANS));
        // normal fails again inside the re-transfer delay
        nrm_det <= 4'hd;
        repeat (3) @(posedge pclk);
        apb(0, REG_STATUS, 0);
        chk(32'({rd[2:0], load_on_alt}), 32'({ST_ON_ALT, 1'b1}));
        nrm_det <= 4'hf;
        wait_sig(0, 1'b0, (RT + 2) * SC);
        // swapped preference
        apb(1, REG_CTRL, 32'ha);
        pref <= 1'b1;
        nrm_det <= 4'h7;
        wait_sig(0, 1'b1, 4);
        nrm_det <= 4'hf;
        wait_sig(0, 1'b0, (RT + 2) * SC);
        apb(1, REG_CTRL, 32'h2);
        pref <= 1'b0;
        // random detections under random enables
        for (int i = 0; i < 20; i++) begin
            en = (i == 0) ? 8'h00 : 8'($urandom);
            apb(1, REG_DET_EN, 32'(en));
            nrm_det <= 4'($urandom);
            alt_det <= (i == 1) ? 4'h0 : 4'($urandom);
            repeat (3) @(posedge pclk);
            apb(0, REG_STATUS, 0);
            rv = 32'({es(nrm_det, en[3:0]), es(alt_det, en[7:4])});
            chk(32'({rd[11:10], rd[13:12]}), rv);
        end
        apb(1, REG_DET_EN, 32'hff);
        nrm_det <= 4'hf;
        alt_det <= 4'hf;
        sec(8);
        chk(32'(load_on_alt), 0);
        // utility-generator sequence
        apb(1, REG_CTRL, 32'h3);
        // indicators lag the mode change by two edges
        repeat (2) @(posedge pclk);
        watch(4);
        chk(ones, 0);
        apb(0, REG_STATUS, 0);
        chk(32'(rd[13:12]), 32'(SRC_OFF));
        nrm_det <= 4'hb;
        wait_sig(1, 1'b1, 3);
        apb(0, REG_STATUS, 0);
        rv = 32'({ST_GEN_START, SRC_OUTR, 1'b0});
        chk(32'({rd[2:0], rd[13:12], load_on_alt}), rv);
        watch(4);
        chk(32'(ones > 0 && ones < 18), 1);
        wait_sig(0, 1'b1, 60);
        nrm_det <= 4'hf;
        chk(32'(gen_cool), 0);
        wait_sig(0, 1'b0, (RT + 2) * SC);
        wait_sig(2, 1'b1, 3);
        sec(58);
        chk(32'(gen_start), 1);
        wait_sig(1, 1'b0, 4 * SC);
        // generator that never starts
        apb(1, REG_CTRL, 32'h7);
        gen_ok <= 1'b0;
        nrm_det <= 4'h0;
        // a generator that never runs shows no voltage on its side
        alt_det <= 4'h0;
        wait_sig(1, 1'b1, 3);
        sec(310);
        chk(32'(gen_alarm), 0);
        ext_power <= 1'b1;
        sec(5);
        apb(1, REG_CMD, 32'h4);
        apb(0, REG_TIMER, 0);
        chk(32'(rd[9:0]), 0);
        sec(298);
        chk(32'(gen_alarm), 0);
        wait_sig(5, 1'b1, 4 * SC);
        nrm_det <= 4'hf;
        wait_sig(5, 1'b0, 3);
        alt_det <= 4'hf;
        ext_power <= 1'b0;
        gen_ok <= 1'b1;
        sec(62);
        // on-load and off-load tests
        for (int i = 0; i < 2; i++) begin
            test_done <= 1'b0;
            apb(1, REG_CMD, 32'(1 << i));
            repeat (3) @(posedge pclk);
            apb(0, REG_ALARM, 0);
            chk(32'(rd[i+1]), 1);
            apb(1, REG_ALARM, 32'(2 << i));
            apb(0, REG_ALARM, 0);
            chk(rd, 0);
            test_done <= 1'b1;
            apb(1, REG_CMD, 32'(1 << i));
            repeat (3) @(posedge pclk);
            apb(0, REG_ALARM, 0);
            chk(rd, 0);
        end
        give_verdict();
    end
endmodule // testbench
